// File: pkg/conv_control_pkg.sv
// Constants shared by the conversion control logic, its checker and its testbench.
// Assumes an 8-bit register port addressed by a small register index.

package conv_control_pkg;

   // ****************************************************************
   // Register indices on the register port.
   // ****************************************************************
   localparam logic [2:0] IDX_SC1     = 3'h0;
   localparam logic [2:0] IDX_SC2     = 3'h1;
   localparam logic [2:0] IDX_RES_HI  = 3'h2;
   localparam logic [2:0] IDX_RES_LO  = 3'h3;
   localparam logic [2:0] IDX_CMP_HI  = 3'h4;
   localparam logic [2:0] IDX_CMP_LO  = 3'h5;
   localparam logic [2:0] IDX_CONFIG  = 3'h6;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int SC1_FLAG_BIT  = 7;
   localparam int SC1_IRQEN_BIT = 6;
   localparam int SC1_CONT_BIT  = 5;
   localparam int SC2_ACT_BIT   = 7;
   localparam int SC2_TRG_BIT   = 6;
   localparam int SC2_CMPE_BIT  = 5;
   localparam int SC2_POL_BIT   = 4;
   localparam int CFG_MODE_LSB  = 2;

   // ****************************************************************
   // Channel codes, mode codes and values after reset.
   // ****************************************************************
   localparam logic [4:0] CH_OFF        = 5'h1F;
   localparam logic [4:0] CH_RESERVED   = 5'h1C;
   localparam logic [4:0] CH_REF_HIGH   = 5'h1D;
   localparam logic [4:0] CH_REF_LOW    = 5'h1E;
   localparam logic [1:0] MODE_8BIT     = 2'h0;
   localparam logic [1:0] MODE_10BIT    = 2'h2;
   localparam logic [4:0] RST_CHANNEL   = CH_OFF;
   localparam logic [1:0] RST_MODE      = MODE_8BIT;
   localparam logic [9:0] RST_CMP_VALUE = 10'h000;

   typedef enum logic {ST_IDLE, ST_CONV} conv_state_e;

endpackage

// File: verilog/result_compare.sv
// Compare unit: judges a conversion result against the programmed value.
// Assumes result and value are right-justified; purely combinational.
`timescale 1ns/10ps

module result_compare #(
   parameter int RES_W = 10
) (
   input  wire logic [RES_W-1:0] result_in,
   input  wire logic [RES_W-1:0] value_in,
   input  wire logic             eight_bit_in,
   input  wire logic             polarity_in,
   output logic                  true_out
);

   logic [RES_W-1:0] res_eff;
   logic [RES_W-1:0] val_eff;
   logic             less;

   // ****************************************************************
   // Comparison.
   // ****************************************************************

   // Narrow mode masks off the upper compare bits.
   always_comb begin
      res_eff = result_in;
      val_eff = value_in;
      if (eight_bit_in) begin
         res_eff = {{(RES_W-8){1'b0}}, result_in[7:0]};
         val_eff = {{(RES_W-8){1'b0}}, value_in[7:0]};
      end
      less     = (res_eff < val_eff);
      true_out = polarity_in ? !less : less;
   end

endmodule

// File: verilog/adc_conversion_control.sv
// Control and status logic of a successive-approximation converter.
// Assumes the analog converter takes one start pulse, answers with one
// done pulse and a result, and stops at once on an abort pulse.
// Assumes the register port strobes are one-cycle pulses.
// A result that completes while the result pair is locked is lost.
`timescale 1ns/10ps

module adc_conversion_control #(
   parameter int RES_W = 10
) (
   input  wire logic             clock_in,
   input  wire logic             rst_in,
   // Register port.
   input  wire logic [2:0]       addr_in,
   input  wire logic [7:0]       wdata_in,
   input  wire logic             wr_in,
   input  wire logic             rd_in,
   output logic      [7:0]       rdata_out,
   // Periodic counter overflow.
   input  wire logic             hw_trigger_in,
   // Converter side.
   output logic                  conv_start_out,
   output logic                  conv_abort_out,
   output logic      [4:0]       conv_channel_out,
   output logic                  conv_power_out,
   output logic                  conv_eight_bit_out,
   input  wire logic             conv_done_in,
   input  wire logic [RES_W-1:0] conv_result_in,
   // Conversion complete interrupt.
   output logic                  complete_irq_out
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   conv_control_pkg::conv_state_e state_r, state_nxt;

   logic             conv_complete_flag_r, conv_complete_flag_nxt;
   logic             complete_irq_enable_r, complete_irq_enable_nxt;
   logic             continuous_select_r, continuous_select_nxt;
   logic [4:0]       channel_select_r, channel_select_nxt;
   logic             trigger_select_r, trigger_select_nxt;
   logic             compare_enable_r, compare_enable_nxt;
   logic             compare_polarity_r, compare_polarity_nxt;
   logic [1:0]       mode_r, mode_nxt;
   logic [RES_W-1:0] cmp_value_r, cmp_value_nxt;
   logic [RES_W-1:0] result_r, result_nxt;
   logic             res_lock_r, res_lock_nxt;
   logic             cont_run_r, cont_run_nxt;
   logic             start_r, start_nxt;
   logic             abort_r, abort_nxt;
   logic             trig_prev_r;
   logic [7:0]       rdata_r, rdata_nxt;

   logic             wr_sc1;
   logic             rd_res_lo;
   logic             rd_res_hi;
   logic             trig_event;
   logic             eight_bit;
   logic [RES_W-1:0] new_result;
   logic             cmp_true;
   logic             stale_done;
   logic             done_ok;

   // ****************************************************************
   // Helper functions.
   // ****************************************************************

   // The all-ones channel code switches the converter off.
   function automatic logic channel_is_off(input logic [4:0] ch);
      channel_is_off = (ch == conv_control_pkg::CH_OFF);
   endfunction

   // Register port hit on a given index with a strobe.
   function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] idx);
      hit = strobe && (a == idx);
   endfunction

   // ****************************************************************
   // Decoding and the compare unit.
   // ****************************************************************

   // Strobe decodes, trigger edge and narrow-mode result shaping.
   always_comb begin
      wr_sc1     = hit(wr_in, addr_in, conv_control_pkg::IDX_SC1);
      rd_res_lo  = hit(rd_in, addr_in, conv_control_pkg::IDX_RES_LO);
      rd_res_hi  = hit(rd_in, addr_in, conv_control_pkg::IDX_RES_HI);
      // Each assertion counts once: only the rising edge is an event.
      trig_event = hw_trigger_in && !trig_prev_r;
      eight_bit  = (mode_r == conv_control_pkg::MODE_8BIT);
      // Narrow mode keeps only the low eight bits that the converter fills.
      if (eight_bit) begin
         new_result = {{(RES_W-8){1'b0}}, conv_result_in[7:0]};
      end else begin
         new_result = conv_result_in;
      end
   end

   // Judges every finished result against the programmed value.
   result_compare #(
      .RES_W        (RES_W)
   ) u_compare (
      .result_in    (new_result),
      .value_in     (cmp_value_r),
      .eight_bit_in (eight_bit),
      .polarity_in  (compare_polarity_r),
      .true_out     (cmp_true)
   );

   // A completion counts only while a conversion runs and no write aborts it.
   // A done beside the abort pulse belongs to the conversion just aborted,
   // so it is dropped as well; the restarted conversion reports later.
   always_comb begin
      stale_done = conv_done_in && abort_r;
      done_ok    = conv_done_in && (state_r == conv_control_pkg::ST_CONV) && !wr_sc1 && !stale_done;
   end

   // ****************************************************************
   // Control registers.
   // ****************************************************************

   // Software-written fields of all control registers.
   always_comb begin
      complete_irq_enable_nxt = complete_irq_enable_r;
      continuous_select_nxt   = continuous_select_r;
      channel_select_nxt      = channel_select_r;
      trigger_select_nxt      = trigger_select_r;
      compare_enable_nxt      = compare_enable_r;
      compare_polarity_nxt    = compare_polarity_r;
      mode_nxt                = mode_r;
      cmp_value_nxt           = cmp_value_r;
      if (wr_in) begin
         if (addr_in == conv_control_pkg::IDX_SC1) begin
            complete_irq_enable_nxt = wdata_in[conv_control_pkg::SC1_IRQEN_BIT];
            continuous_select_nxt   = wdata_in[conv_control_pkg::SC1_CONT_BIT];
            channel_select_nxt      = wdata_in[4:0];
         end else if (addr_in == conv_control_pkg::IDX_SC2) begin
            // Bits 7 and 3:0 are read-only or reserved and are not stored.
            trigger_select_nxt   = wdata_in[conv_control_pkg::SC2_TRG_BIT];
            compare_enable_nxt   = wdata_in[conv_control_pkg::SC2_CMPE_BIT];
            compare_polarity_nxt = wdata_in[conv_control_pkg::SC2_POL_BIT];
         end else if (addr_in == conv_control_pkg::IDX_CMP_HI) begin
            // Only the bits above the low byte exist in this register.
            cmp_value_nxt[RES_W-1:8] = wdata_in[RES_W-9:0];
         end else if (addr_in == conv_control_pkg::IDX_CMP_LO) begin
            cmp_value_nxt[7:0] = wdata_in;
         end else if (addr_in == conv_control_pkg::IDX_CONFIG) begin
            // A mode change leaves the stored result as it is.
            mode_nxt = wdata_in[conv_control_pkg::CFG_MODE_LSB +: 2];
         end
      end
   end

   // Registers the control fields.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         complete_irq_enable_r <= 1'b0;
         continuous_select_r   <= 1'b0;
         channel_select_r      <= conv_control_pkg::RST_CHANNEL;
         trigger_select_r      <= 1'b0;
         compare_enable_r      <= 1'b0;
         compare_polarity_r    <= 1'b0;
         mode_r                <= conv_control_pkg::RST_MODE;
         cmp_value_r           <= conv_control_pkg::RST_CMP_VALUE;
      end else begin
         complete_irq_enable_r <= complete_irq_enable_nxt;
         continuous_select_r   <= continuous_select_nxt;
         channel_select_r      <= channel_select_nxt;
         trigger_select_r      <= trigger_select_nxt;
         compare_enable_r      <= compare_enable_nxt;
         compare_polarity_r    <= compare_polarity_nxt;
         mode_r                <= mode_nxt;
         cmp_value_r           <= cmp_value_nxt;
      end
   end

   // ****************************************************************
   // Conversion sequencer.
   // ****************************************************************

   // Starts, aborts and repeats conversions.
   always_comb begin
      state_nxt    = state_r;
      cont_run_nxt = cont_run_r;
      start_nxt    = 1'b0;
      abort_nxt    = 1'b0;
      if (wr_sc1) begin
         // Any write ends what runs now.
         abort_nxt    = (state_r == conv_control_pkg::ST_CONV);
         state_nxt    = conv_control_pkg::ST_IDLE;
         cont_run_nxt = 1'b0;
         if (!channel_is_off(wdata_in[4:0]) && !trigger_select_r) begin
            start_nxt    = 1'b1;
            state_nxt    = conv_control_pkg::ST_CONV;
            cont_run_nxt = wdata_in[conv_control_pkg::SC1_CONT_BIT];
         end
      end else begin
         case (state_r)
            conv_control_pkg::ST_IDLE: begin
               // Triggers count only in hardware mode with the converter on.
               if (trig_event && trigger_select_r && !channel_is_off(channel_select_r)) begin
                  start_nxt    = 1'b1;
                  state_nxt    = conv_control_pkg::ST_CONV;
                  cont_run_nxt = continuous_select_r;
               end
            end
            conv_control_pkg::ST_CONV: begin
               // A done from an aborted conversion must not end the new one.
               if (conv_done_in && !stale_done) begin
                  // Restart only while the run began in continuous mode.
                  if (cont_run_r && continuous_select_r) begin
                     start_nxt = 1'b1;
                  end else begin
                     state_nxt    = conv_control_pkg::ST_IDLE;
                     cont_run_nxt = 1'b0;
                  end
               end
            end
            default: begin
               // Guards against an illegal state code.
               state_nxt = conv_control_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Registers the sequencer.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_r     <= conv_control_pkg::ST_IDLE;
         cont_run_r  <= 1'b0;
         start_r     <= 1'b0;
         abort_r     <= 1'b0;
         // The trigger history resets to the idle level of its input.
         trig_prev_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cont_run_r  <= cont_run_nxt;
         start_r     <= start_nxt;
         abort_r     <= abort_nxt;
         trig_prev_r <= hw_trigger_in;
      end
   end

   // ****************************************************************
   // Complete flag and results.
   // ****************************************************************

   // A finished conversion that passes any enabled compare sets the flag and, unless locked, loads the result.
   always_comb begin
      conv_complete_flag_nxt = conv_complete_flag_r;
      result_nxt             = result_r;
      res_lock_nxt           = res_lock_r;
      if (wr_sc1 || rd_res_lo) begin
         conv_complete_flag_nxt = 1'b0;
      end
      // In 8-bit mode there is no high byte to pair, so no lock.
      if (rd_res_lo || eight_bit) begin
         res_lock_nxt = 1'b0;
      end else if (rd_res_hi) begin
         // High byte read holds the pair until the low byte is read.
         res_lock_nxt = 1'b1;
      end
      // The set comes last so that it wins over a clear in one cycle.
      if (done_ok && (!compare_enable_r || cmp_true)) begin
         conv_complete_flag_nxt = 1'b1;
         if (!res_lock_r) begin
            result_nxt = new_result;
         end
      end
   end

   // Registers the flag and the result.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         conv_complete_flag_r <= 1'b0;
         result_r             <= '0;
         res_lock_r           <= 1'b0;
      end else begin
         conv_complete_flag_r <= conv_complete_flag_nxt;
         result_r             <= result_nxt;
         res_lock_r           <= res_lock_nxt;
      end
   end

   // ****************************************************************
   // Read port.
   // ****************************************************************

   // Selects the read data; unmapped indices read zero.
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_in) begin
         if (addr_in == conv_control_pkg::IDX_SC1) begin
            rdata_nxt = {conv_complete_flag_r, complete_irq_enable_r,
                         continuous_select_r, channel_select_r};
         end else if (addr_in == conv_control_pkg::IDX_SC2) begin
            // The active bit is the sequencer state, so an abort that starts no new conversion clears it at once.
            rdata_nxt = {(state_r == conv_control_pkg::ST_CONV), trigger_select_r,
                         compare_enable_r, compare_polarity_r, 4'h0};
         end else if (addr_in == conv_control_pkg::IDX_RES_HI) begin
            rdata_nxt = eight_bit ? 8'h00 : {{(16-RES_W){1'b0}}, result_r[RES_W-1:8]};
         end else if (addr_in == conv_control_pkg::IDX_RES_LO) begin
            rdata_nxt = result_r[7:0];
         end else if (addr_in == conv_control_pkg::IDX_CMP_HI) begin
            rdata_nxt = {{(16-RES_W){1'b0}}, cmp_value_r[RES_W-1:8]};
         end else if (addr_in == conv_control_pkg::IDX_CMP_LO) begin
            rdata_nxt = cmp_value_r[7:0];
         end else if (addr_in == conv_control_pkg::IDX_CONFIG) begin
            rdata_nxt = {4'h0, mode_r, 2'h0};
         end
      end
   end

   // Read data stand only in the cycle after the strobe.
   // Zero outside that cycle keeps stale data off the shared read bus.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************

   // Drives the converter, read data and interrupt.
   always_comb begin
      rdata_out          = rdata_r;
      conv_start_out     = start_r;
      conv_abort_out     = abort_r;
      conv_eight_bit_out = eight_bit;
      // Off channel isolates all inputs; idle in single mode is low power.
      conv_channel_out   = channel_select_r;
      conv_power_out     = !channel_is_off(channel_select_r)
                           && ((state_r == conv_control_pkg::ST_CONV) || cont_run_r);
      // The interrupt is a level that falls with the flag or the enable.
      complete_irq_out   = conv_complete_flag_r && complete_irq_enable_r;
   end

endmodule

// File: sim/conv_model.sv
// Behavioural converter on the far side of the control logic.
// Assumes one-cycle start and abort pulses from the control logic.
`timescale 1ns/10ps

module conv_model (
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   input  wire logic       start_in,
   input  wire logic       abort_in,
   input  wire logic [7:0] delay_in,
   input  wire logic [9:0] value_in,
   output logic            done_out,
   output logic [9:0]      result_out
);
   logic [7:0] cnt_r;

   // Counts a conversion down and pulses done; a start wins over an abort.
   always_ff @(posedge clock_in) begin
      done_out <= 1'b0;
      if (rst_in) begin
         cnt_r <= 8'h00;
      end else if (start_in) begin
         cnt_r <= delay_in;
      end else if (abort_in) begin
         cnt_r <= 8'h00;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
         done_out <= (cnt_r == 8'h01);
      end
   end

   // The result is only valid beside done; elsewhere it shows the inverse.
   assign result_out = done_out ? value_in : ~value_in;
endmodule

// File: sim/adc_conversion_control_assertions.sv
// Checker for the conversion control ports.
// Assumes it is bound onto adc_conversion_control and sees its ports only.
`timescale 1ns/10ps

module conv_control_checker #(
   parameter int RES_W = 10
) (
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       hw_trigger_in,
   input wire logic       conv_start_out,
   input wire logic       conv_abort_out,
   input wire logic [4:0] conv_channel_out,
   input wire logic       conv_power_out,
   input wire logic       conv_done_in,
   input wire logic       complete_irq_out
);
   logic       trg_r;
   logic       cont_r;
   logic       act_r;
   logic       cause_r;
   logic       trig_d_r;
   logic [4:0] wd_r;
   logic       wr1;
   logic       on1;

   // Decodes a write to the first control register and its channel field.
   assign wr1 = wr_in && (addr_in == conv_control_pkg::IDX_SC1);
   assign on1 = wdata_in[4:0] != conv_control_pkg::CH_OFF;

   // Mirrors trigger mode, continuous mode, activity and start causes.
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         trg_r <= 1'b0;
         cont_r <= 1'b0;
         act_r <= 1'b0;
         cause_r <= 1'b0;
         trig_d_r <= 1'b0;
      end else begin
         if (wr_in && addr_in == conv_control_pkg::IDX_SC2) trg_r <= wdata_in[6];
         if (wr1) cont_r <= wdata_in[5];
         act_r <= conv_start_out | (act_r & ~conv_done_in & ~conv_abort_out & ~wr1);
         cause_r <= wr1 | conv_done_in | (hw_trigger_in & ~trig_d_r);
         trig_d_r <= hw_trigger_in;
      end
      wd_r <= wdata_in[4:0];
   end

   // ****************************************************************
   // Port relations.
   // ****************************************************************
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);

   start_write_a:
      assert property (wr1 && on1 && !trg_r |=> conv_start_out) else $error("No start after write.");
   off_write_a:
      assert property (wr1 && !on1 |=> !conv_start_out && !conv_power_out) else $error("Off channel ran.");
   flag_clear_a:
      assert property (wr1 |=> !complete_irq_out) else $error("Flag kept after write.");
   irq_cause_a:
      assert property ($rose(complete_irq_out) |-> $past(conv_done_in)) else $error("Interrupt without end.");
   channel_follow_a:
      assert property (wr1 |=> conv_channel_out == wd_r) else $error("Channel not taken.");
   abort_write_a:
      assert property (wr1 && (act_r || conv_start_out) && !conv_done_in |=> conv_abort_out)
         else $error("No abort on write.");
   single_idle_a:
      assert property (conv_done_in && act_r && !cont_r && !wr1 |=> !conv_start_out && !conv_power_out)
         else $error("Single mode did not idle.");
   cont_restart_a:
      assert property (conv_done_in && act_r && cont_r && !wr1 |=> conv_start_out) else $error("No restart.");
   hw_start_a:
      assert property ($rose(hw_trigger_in) && trg_r && !act_r && !conv_start_out && !wr_in &&
         conv_channel_out != conv_control_pkg::CH_OFF |=> conv_start_out) else $error("Trigger lost.");
   start_cause_a:
      assert property (conv_start_out |-> cause_r) else $error("Start without cause.");

   // Main scenarios reached.
   cover property (conv_abort_out);
   cover property (conv_done_in && cont_r);
   cover property ($rose(complete_irq_out));
endmodule

bind adc_conversion_control conv_control_checker #(.RES_W(RES_W)) chk (.clock_in(clock_in), .rst_in(rst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .hw_trigger_in(hw_trigger_in),
   .conv_start_out(conv_start_out), .conv_abort_out(conv_abort_out), .conv_channel_out(conv_channel_out),
   .conv_power_out(conv_power_out), .conv_done_in(conv_done_in), .complete_irq_out(complete_irq_out));

// File: sim/adc_conversion_control_tb_top.sv
// Testbench of the conversion control logic with a behavioural converter.
// Assumes the package and design files are compiled before it.
`timescale 1ns/10ps

module adc_conversion_control_tb_top;
   typedef struct {logic [7:0] sc2; logic [7:0] cmp; logic [7:0] res; logic flag;} row_s;
   logic       clock_in = 1'b0;
   logic       rst_in = 1'b1;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in = 1'b0;
   logic       rd_in = 1'b0;
   logic       hw_trigger_in = 1'b0;
   logic [7:0] delay = 8'h04;
   logic [9:0] value = 10'h000;
   logic [7:0] rdata_out;
   logic [7:0] rd_val;
   logic [7:0] last;
   logic [4:0] conv_channel_out;
   logic [9:0] conv_result_in;
   logic       conv_start_out;
   logic       conv_abort_out;
   logic       conv_power_out;
   logic       conv_eight_bit_out;
   logic       conv_done_in;
   logic       complete_irq_out;
   int         error_cnt = 0;
   int         check_count = 0;
   int         start_cnt = 0;
   int         abort_cnt = 0;
   int         s;
   int         a;
   row_s       rows [5] = '{'{8'h00, 8'h40, 8'h30, 1'b1}, '{8'h20, 8'h40, 8'h30, 1'b1},
      '{8'h20, 8'h40, 8'h50, 1'b0}, '{8'h30, 8'h40, 8'h40, 1'b1}, '{8'h30, 8'h40, 8'h3F, 1'b0}};

   adc_conversion_control DUT (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .hw_trigger_in(hw_trigger_in),
      .conv_start_out(conv_start_out), .conv_abort_out(conv_abort_out), .conv_channel_out(conv_channel_out),
      .conv_power_out(conv_power_out), .conv_eight_bit_out(conv_eight_bit_out), .conv_done_in(conv_done_in),
      .conv_result_in(conv_result_in), .complete_irq_out(complete_irq_out));
   conv_model partner (.clock_in(clock_in), .rst_in(rst_in), .start_in(conv_start_out),
      .abort_in(conv_abort_out), .delay_in(delay), .value_in(value), .done_out(conv_done_in),
      .result_out(conv_result_in));

   // Clock of 10 ns and start and abort pulse counters.
   always #5 clock_in = ~clock_in;
   always @(negedge clock_in) begin
      start_cnt += int'(conv_start_out);
      abort_cnt += int'(conv_abort_out);
   end

   // ****************************************************************
   // Bus cycles, comparison and closing.
   // ****************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] ad, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= ad;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] ad);
      @(posedge clock_in);
      addr_in <= ad;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 rd_val = rdata_out;
   endtask
   task automatic wait_done();
      for (int i = 0; i < 200 && !conv_done_in; i++) @(posedge clock_in);
      if (!conv_done_in) error_cnt++;
      repeat (2) @(posedge clock_in);
      #1;
   endtask
   task automatic pulse_trig();
      @(posedge clock_in);
      hw_trigger_in <= 1'b1;
      @(posedge clock_in);
      hw_trigger_in <= 1'b0;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog against a hang.
   initial begin
      #100000;
      error_cnt++;
      final_report();
   end

   // Reset, table of compare cases, then the awkward cases.
   initial begin
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      #1 chk(conv_power_out, 1'b0);
      chk(conv_channel_out, conv_control_pkg::CH_OFF);
      chk(conv_eight_bit_out, 1'b1);
      rd(3'h7);
      chk(rd_val, 8'h00);
      wr(conv_control_pkg::IDX_CMP_HI, 8'h03);
      foreach (rows[i]) begin
         wr(conv_control_pkg::IDX_SC2, rows[i].sc2);
         wr(conv_control_pkg::IDX_CMP_LO, rows[i].cmp);
         value <= {2'h0, rows[i].res};
         s = start_cnt;
         wr(conv_control_pkg::IDX_SC1, 8'h43);
         wait_done();
         chk(start_cnt - s, 8'h01);
         chk(complete_irq_out, rows[i].flag);
         if (rows[i].flag) last = rows[i].res;
         rd(conv_control_pkg::IDX_RES_LO);
         chk(rd_val, last);
         rd(conv_control_pkg::IDX_SC1);
         chk(rd_val[7], 1'b0);
      end
      wr(conv_control_pkg::IDX_SC2, 8'h00);
      delay <= 8'd20;
      wr(conv_control_pkg::IDX_SC1, 8'h03);
      rd(conv_control_pkg::IDX_SC2);
      chk(rd_val, 8'h80);
      s = start_cnt;
      a = abort_cnt;
      wr(conv_control_pkg::IDX_SC1, 8'h03);
      wr(conv_control_pkg::IDX_SC1, 8'h1F);
      repeat (30) @(posedge clock_in);
      chk(abort_cnt - a, 8'h02);
      chk(start_cnt - s, 8'h01);
      rd(conv_control_pkg::IDX_SC2);
      chk(rd_val, 8'h00);
      delay <= 8'd3;
      s = start_cnt;
      wr(conv_control_pkg::IDX_SC1, 8'h23);
      repeat (20) @(posedge clock_in);
      chk(start_cnt - s > 3, 1'b1);
      wr(conv_control_pkg::IDX_SC1, 8'h3F);
      s = start_cnt;
      repeat (20) @(posedge clock_in);
      chk(start_cnt - s, 8'h00);
      wr(conv_control_pkg::IDX_SC1, 8'h03);
      wait_done();
      s = start_cnt;
      pulse_trig();
      repeat (10) @(posedge clock_in);
      chk(start_cnt - s, 8'h00);
      wr(conv_control_pkg::IDX_SC2, 8'h40);
      wr(conv_control_pkg::IDX_SC1, 8'h43);
      repeat (10) @(posedge clock_in);
      chk(start_cnt - s, 8'h00);
      pulse_trig();
      wait_done();
      chk(start_cnt - s, 8'h01);
      chk(complete_irq_out, 1'b1);
      wr(conv_control_pkg::IDX_SC1, 8'h03);
      pulse_trig();
      wait_done();
      chk(complete_irq_out, 1'b0);
      rd(conv_control_pkg::IDX_SC1);
      chk(rd_val[7], 1'b1);
      wr(conv_control_pkg::IDX_CONFIG, 8'h08);
      value <= 10'h2A5;
      pulse_trig();
      wait_done();
      chk(conv_eight_bit_out, 1'b0);
      rd(conv_control_pkg::IDX_RES_HI);
      chk(rd_val, 8'h02);
      pulse_trig();
      value <= 10'h15A;
      wait_done();
      rd(conv_control_pkg::IDX_RES_LO);
      chk(rd_val, 8'hA5);
      final_report();
   end
endmodule
